// [shared/unb_pkg.sv]
/*
  Shared constants and types for the nine-bit serial port.
  Assumes a 32-bit APB bus on a single 25 MHz clock.
*/
`default_nettype none

package unb_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [11:0] UNB_SERIAL_CONTROL_OFS = 12'h000;
  localparam logic [11:0] UNB_SERIAL_BUFFER_OFS  = 12'h004;
  localparam logic [11:0] UNB_POWER_CONTROL_OFS  = 12'h008;
  localparam logic [11:0] UNB_TIMER2_CONTROL_OFS = 12'h00C;

  // ==========================================================================
  // Field positions
  localparam int UNB_TX_DONE_BIT   = 0;
  localparam int UNB_RX_DONE_BIT   = 1;
  localparam int UNB_RX_NINTH_BIT  = 2;
  localparam int UNB_TX_NINTH_BIT  = 3;
  localparam int UNB_MPF_BIT       = 4;
  localparam int UNB_RX_ENABLE_BIT = 5;
  localparam int UNB_MODE_BIT      = 6;
  localparam int UNB_SEND_BIT      = 7;
  localparam int UNB_RX_BUSY_BIT   = 8;
  localparam int UNB_DOUBLER_BIT   = 7;
  localparam int UNB_TX_CSEL_BIT   = 4;
  localparam int UNB_RX_CSEL_BIT   = 5;

  // ==========================================================================
  // Values after reset
  localparam logic [8:0] UNB_RX_SHIFT_INIT = 9'h1FF;
  localparam logic [8:0] UNB_TX_SHIFT_RST  = 9'h1FF;
  localparam logic [7:0] UNB_BUF_RST       = 8'h00;

  // ==========================================================================
  // Rates and counts
  localparam int UNB_CLK_HZ        = 25_000_000;
  localparam int UNB_FIXED_DIV     = 64;
  localparam int UNB_OVERSAMPLE    = 16;
  localparam int UNB_PRESCALE_SLOW = UNB_FIXED_DIV / UNB_OVERSAMPLE;
  localparam int UNB_PRESCALE_FAST = UNB_PRESCALE_SLOW / 2;
  localparam logic [3:0] UNB_CNT_LAST  = 4'hF;
  localparam logic [3:0] UNB_SAMPLE_A  = 4'h7;
  localparam logic [3:0] UNB_SAMPLE_B  = 4'h8;
  localparam logic [3:0] UNB_SAMPLE_C  = 4'h9;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {UNB_RX_HUNT, UNB_RX_BITS, UNB_RX_TAIL} unb_rx_state_t;

  typedef struct packed {
    logic tx_ninth_bit;
    logic multiproc_filter;
    logic rx_enable;
    logic variable_mode;
  } unb_ctrl_t;

  typedef struct packed {
    logic baud_doubler;
    logic tx_clock_select;
    logic rx_clock_select;
  } unb_rate_t;

endpackage : unb_pkg

`default_nettype wire

// [logic/unb_serial_port.sv]
/*
  Nine-bit asynchronous serial port: fixed-rate and variable-rate modes, APB slave.
  Assumes timer overflow strobes are one-cycle pulses on pclk; rx_line is asynchronous.
*/
// The register offsets and the APB register port were left to the implementer.
`default_nettype none

// What this block does
// - Frame is start, 8 LSB-first, ninth, stop
// - Transmitted ninth bit comes from tx_ninth_bit
// - Fixed mode rate osc/64, osc/32 when doubled
// - Variable mode rate from selected timer overflow
// - Buffer write while not sending loads shifter and ninth bit, requests
// - Transmission starts at next counter rollover
// - Start bit, then data, then shifting
// - First shift inserts one, later zeros
// - Stop condition: last shift, end, set done
// - Receiver oversamples, starts on falling edge
// - Falling edge resets counter, loads 1FF
// - Majority of samples seven, eight, nine
// - Non-zero start bit returns to hunting
// - Nine-bit receive shifter, final shift at start
// - Load only if done clear and filter passes
// - Failed conditions discard frame, flag untouched
// - Load ninth bit, byte, set done flag
// - Hunt again fifteen ticks after final shift
// - Received stop bit value is ignored

module unb_serial_port
  import unb_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        timer1_ovf,
  input  wire logic        timer2_ovf,
  input  wire logic        rx_line,
  output var  logic        tx_line
);

  // ==========================================================================
  // Registers and strobes
  unb_ctrl_t     ctrl_reg;
  unb_rate_t     rate_reg;
  logic          tx_done_flag;
  logic          rx_done_flag;
  logic          rx_ninth_bit;
  logic [7:0]    rx_buf_reg;
  logic          acc_wr;
  logic          acc_rd;
  logic          wr_ctrl;
  logic          wr_buf;
  logic          clr_tx_done;
  logic          clr_rx_done;
  logic          mapped;

  assign acc_wr      = psel && penable && pwrite;
  assign acc_rd      = psel && !penable && !pwrite;
  assign wr_ctrl     = acc_wr && (paddr == UNB_SERIAL_CONTROL_OFS);
  assign wr_buf      = acc_wr && (paddr == UNB_SERIAL_BUFFER_OFS);
  assign clr_tx_done = wr_ctrl && pwdata[UNB_TX_DONE_BIT];
  assign clr_rx_done = wr_ctrl && pwdata[UNB_RX_DONE_BIT];
  assign mapped      = (paddr == UNB_SERIAL_CONTROL_OFS) || (paddr == UNB_SERIAL_BUFFER_OFS) ||
                       (paddr == UNB_POWER_CONTROL_OFS) || (paddr == UNB_TIMER2_CONTROL_OFS);
  assign pready      = 1'b1;

  // ==========================================================================
  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
      rate_reg <= '0;
    end else if (acc_wr) begin
      if (paddr == UNB_SERIAL_CONTROL_OFS) begin
        ctrl_reg.tx_ninth_bit     <= pwdata[UNB_TX_NINTH_BIT];
        ctrl_reg.multiproc_filter <= pwdata[UNB_MPF_BIT];
        ctrl_reg.rx_enable        <= pwdata[UNB_RX_ENABLE_BIT];
        ctrl_reg.variable_mode    <= pwdata[UNB_MODE_BIT];
      end
      if (paddr == UNB_POWER_CONTROL_OFS) begin
        rate_reg.baud_doubler <= pwdata[UNB_DOUBLER_BIT];
      end
      if (paddr == UNB_TIMER2_CONTROL_OFS) begin
        rate_reg.tx_clock_select <= pwdata[UNB_TX_CSEL_BIT];
        rate_reg.rx_clock_select <= pwdata[UNB_RX_CSEL_BIT];
      end
    end
  end

  // ==========================================================================
  // Rate ticks at sixteen times the bit rate
  logic [1:0] pre_cnt;
  logic       fixed_tick;
  logic       tx_tick;
  logic       rx_tick;
  logic [1:0] pre_last;

  assign pre_last   = rate_reg.baud_doubler ? 2'(UNB_PRESCALE_FAST - 1) : 2'(UNB_PRESCALE_SLOW - 1);
  assign fixed_tick = (pre_cnt >= pre_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 2'h0;
    end else if (fixed_tick) begin
      pre_cnt <= 2'h0;
    end else begin
      pre_cnt <= pre_cnt + 2'h1;
    end
  end

  assign tx_tick = ctrl_reg.variable_mode ? (rate_reg.tx_clock_select ? timer2_ovf : timer1_ovf)
                                          : fixed_tick;
  assign rx_tick = ctrl_reg.variable_mode ? (rate_reg.rx_clock_select ? timer2_ovf : timer1_ovf)
                                          : fixed_tick;

  // ==========================================================================
  // Transmitter
  logic [3:0] tx_cnt;
  logic       tx_roll;
  logic       tx_pending;
  logic       send_phase;
  logic       data_phase;
  logic       tx_shifted;
  logic [8:0] tx_shift_reg;
  logic       tx_stop_cond;
  logic       tx_finish;
  logic [7:0] tx_byte_reg;

  assign tx_roll      = tx_tick && (tx_cnt == UNB_CNT_LAST);
  assign tx_stop_cond = tx_shifted && (tx_shift_reg[8:2] == 7'h00) && tx_shift_reg[1];
  assign tx_finish    = tx_roll && send_phase && data_phase && tx_stop_cond;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt <= 4'h0;
    end else if (tx_tick) begin
      tx_cnt <= tx_cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pending   <= 1'b0;
      send_phase   <= 1'b0;
      data_phase   <= 1'b0;
      tx_shifted   <= 1'b0;
      tx_shift_reg <= UNB_TX_SHIFT_RST;
      tx_byte_reg  <= UNB_BUF_RST;
    end else if (wr_buf && !send_phase) begin
      tx_shift_reg <= {ctrl_reg.tx_ninth_bit, pwdata[7:0]};
      tx_byte_reg  <= pwdata[7:0];
      tx_pending   <= 1'b1;
    end else if (tx_roll) begin
      if (!send_phase && tx_pending) begin
        send_phase <= 1'b1;
        tx_pending <= 1'b0;
      end else if (send_phase && !data_phase) begin
        data_phase <= 1'b1;
      end else if (send_phase && tx_stop_cond) begin
        tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
        send_phase   <= 1'b0;
        data_phase   <= 1'b0;
        tx_shifted   <= 1'b0;
      end else if (send_phase) begin
        tx_shift_reg <= {!tx_shifted, tx_shift_reg[8:1]};
        tx_shifted   <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_line <= 1'b1;
    end else begin
      tx_line <= !send_phase ? 1'b1 : (data_phase ? tx_shift_reg[0] : 1'b0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_done_flag <= 1'b0;
    end else if (tx_finish) begin
      tx_done_flag <= 1'b1;
    end else if (clr_tx_done) begin
      tx_done_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Receive line synchroniser and sampler
  logic       rx_meta;
  logic       rx_sync;
  logic       rx_prev;
  logic [2:0] rx_samp;
  logic       rx_major;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_line;
      rx_sync <= rx_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev <= 1'b1;
    end else if (rx_tick) begin
      rx_prev <= rx_sync;
    end
  end

  // ==========================================================================
  // Receiver
  unb_rx_state_t rx_state;
  logic [3:0]    rx_cnt;
  logic [8:0]    rx_shift_reg;
  logic          rx_fall;
  logic          rx_decide;
  logic [8:0]    rx_next;
  logic          rx_final;
  logic          rx_load_ok;

  assign rx_fall    = rx_tick && ctrl_reg.rx_enable && rx_prev && !rx_sync;
  assign rx_major   = (rx_samp[0] & rx_samp[1]) | (rx_samp[1] & rx_sync) | (rx_samp[0] & rx_sync);
  assign rx_decide  = rx_tick && (rx_cnt == UNB_SAMPLE_C) && (rx_state == UNB_RX_BITS);
  assign rx_next    = {rx_shift_reg[7:0], rx_major};
  assign rx_final   = rx_decide && !rx_shift_reg[8] && (rx_shift_reg != UNB_RX_SHIFT_INIT);
  assign rx_load_ok = !rx_done_flag && (!ctrl_reg.multiproc_filter || rx_major);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_samp <= 3'h7;
    end else if (rx_tick && ((rx_cnt == UNB_SAMPLE_A) || (rx_cnt == UNB_SAMPLE_B))) begin
      rx_samp <= {rx_samp[1:0], rx_sync};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state     <= UNB_RX_HUNT;
      rx_cnt       <= 4'h0;
      rx_shift_reg <= UNB_RX_SHIFT_INIT;
    end else begin
      case (rx_state)
        UNB_RX_HUNT: begin
          if (rx_fall) begin
            rx_cnt       <= 4'h0;
            rx_shift_reg <= UNB_RX_SHIFT_INIT;
            rx_state     <= UNB_RX_BITS;
          end
        end
        UNB_RX_BITS: begin
          if (rx_tick) begin
            rx_cnt <= rx_cnt + 4'h1;
          end
          if (rx_decide) begin
            if (rx_shift_reg == UNB_RX_SHIFT_INIT && rx_major) begin
              rx_state <= UNB_RX_HUNT;
            end else begin
              rx_shift_reg <= rx_next;
              if (rx_final) begin
                rx_state <= UNB_RX_TAIL;
              end
            end
          end
        end
        UNB_RX_TAIL: begin
          if (rx_tick) begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == UNB_SAMPLE_B) begin
              rx_state <= UNB_RX_HUNT;
            end
          end
        end
        default: begin
          rx_state <= UNB_RX_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_reg   <= UNB_BUF_RST;
      rx_ninth_bit <= 1'b0;
    end else if (rx_final && rx_load_ok) begin
      rx_ninth_bit <= rx_major;
      rx_buf_reg   <= {rx_next[1], rx_next[2], rx_next[3], rx_next[4],
                       rx_next[5], rx_next[6], rx_next[7], rx_next[8]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_done_flag <= 1'b0;
    end else if (rx_final && rx_load_ok) begin
      rx_done_flag <= 1'b1;
    end else if (clr_rx_done) begin
      rx_done_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Read data and error, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !mapped;
      prdata  <= 32'h0000_0000;
      if (acc_rd) begin
        case (paddr)
          UNB_SERIAL_CONTROL_OFS: begin
            prdata[UNB_TX_DONE_BIT]   <= tx_done_flag;
            prdata[UNB_RX_DONE_BIT]   <= rx_done_flag;
            prdata[UNB_RX_NINTH_BIT]  <= rx_ninth_bit;
            prdata[UNB_TX_NINTH_BIT]  <= ctrl_reg.tx_ninth_bit;
            prdata[UNB_MPF_BIT]       <= ctrl_reg.multiproc_filter;
            prdata[UNB_RX_ENABLE_BIT] <= ctrl_reg.rx_enable;
            prdata[UNB_MODE_BIT]      <= ctrl_reg.variable_mode;
            prdata[UNB_SEND_BIT]      <= send_phase;
            prdata[UNB_RX_BUSY_BIT]   <= (rx_state != UNB_RX_HUNT);
          end
          UNB_SERIAL_BUFFER_OFS:  prdata[7:0] <= rx_buf_reg;
          UNB_POWER_CONTROL_OFS:  prdata[UNB_DOUBLER_BIT] <= rate_reg.baud_doubler;
          UNB_TIMER2_CONTROL_OFS: begin
            prdata[UNB_TX_CSEL_BIT] <= rate_reg.tx_clock_select;
            prdata[UNB_RX_CSEL_BIT] <= rate_reg.rx_clock_select;
          end
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  property p_idle_high;
    @(posedge pclk) disable iff (!presetn) !send_phase |=> tx_line;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("Line not high while idle");

  property p_start_low;
    @(posedge pclk) disable iff (!presetn) (send_phase && !data_phase) |=> !tx_line;
  endproperty
  a_start_low: assert property (p_start_low) else $error("Start bit not low");

  property p_start_on_roll;
    @(posedge pclk) disable iff (!presetn) $rose(send_phase) |-> $past(tx_roll) && $past(tx_pending);
  endproperty
  a_start_on_roll: assert property (p_start_on_roll) else $error("Send began off rollover");

  property p_done_set;
    @(posedge pclk) disable iff (!presetn) tx_finish |=> tx_done_flag && !send_phase;
  endproperty
  a_done_set: assert property (p_done_set) else $error("Transmit done not set");

  property p_fixed_rate;
    @(posedge pclk) disable iff (!presetn)
      (fixed_tick && !rate_reg.baud_doubler) ##1 (!rate_reg.baud_doubler) [*4]
        |-> fixed_tick && !$past(fixed_tick) && !$past(fixed_tick, 2) && !$past(fixed_tick, 3);
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("Fixed tick spacing wrong");

  property p_rx_arm;
    @(posedge pclk) disable iff (!presetn)
      (rx_state == UNB_RX_HUNT && rx_fall) |=> rx_cnt == 4'h0 && rx_shift_reg == UNB_RX_SHIFT_INIT;
  endproperty
  a_rx_arm: assert property (p_rx_arm) else $error("Receiver not armed on edge");

  property p_false_start;
    @(posedge pclk) disable iff (!presetn)
      (rx_decide && rx_shift_reg == UNB_RX_SHIFT_INIT && rx_major) |=> rx_state == UNB_RX_HUNT;
  endproperty
  a_false_start: assert property (p_false_start) else $error("False start accepted");

  property p_discard;
    @(posedge pclk) disable iff (!presetn) (rx_final && !rx_load_ok) |=> $stable(rx_buf_reg) && $stable(rx_ninth_bit);
  endproperty
  a_discard: assert property (p_discard) else $error("Discarded frame changed buffer");

  property p_load;
    @(posedge pclk) disable iff (!presetn) (rx_final && rx_load_ok) |=> rx_done_flag && rx_ninth_bit == $past(rx_major);
  endproperty
  a_load: assert property (p_load) else $error("Frame not loaded");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn) (rx_done_flag && !clr_rx_done) |=> rx_done_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("Receive flag cleared by hardware");

endmodule : unb_serial_port

`default_nettype wire

// [tb/unb_remote_node.sv]
/*
  Remote serial node model facing the port's tx_line and rx_line.
  Assumes the bench gives bit lengths in pclk cycles; its line idles high.
*/
`default_nettype none

module unb_remote_node (
  input  wire logic pclk,
  input  wire logic tx_line,
  output var  logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [10:0] cap;
  int          cap_n = 0;
  int          rx_bc = 64;

  initial rx_line = 1'b1;

  // ==========================================================================
  // Frame capture, sampled mid-bit
  always begin
    @(negedge tx_line);
    repeat (rx_bc / 2) @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      cap[i] = tx_line;
      if (i < 10) repeat (rx_bc) @(posedge pclk);
    end
    cap_n++;
  end

  // ==========================================================================
  // Frame and noise senders
  task automatic send_frame(input logic [7:0] d, input logic n9, input logic stop, input int bc);
    logic [10:0] f;
    f = {stop, n9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge pclk);
      rx_line <= f[i];
      repeat (bc - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rx_line <= 1'b1;
  endtask : send_frame

  task automatic glitch(input int n);
    @(posedge pclk);
    rx_line <= 1'b0;
    repeat (n) @(posedge pclk);
    rx_line <= 1'b1;
  endtask : glitch

endmodule : unb_remote_node

`default_nettype wire

// [tb/unb_serial_port_test.sv]
/*
  Self-checking bench for the nine-bit serial port.
  Assumes the remote node model and the port share pclk.
*/
`default_nettype none

module unb_serial_port_test
  import unb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, pready, pslverr, rx_line, tx_line, er;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        timer1_ovf = 1'b0, timer2_ovf = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, ctl_v;
  int          fail_count = 0, cmp_count = 0, tcnt = 0;

  unb_serial_port u_unb_serial_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timer1_ovf, .timer2_ovf, .rx_line, .tx_line);
  unb_remote_node u_unb_remote_node (.pclk, .tx_line, .rx_line);

  // ==========================================================================
  // Clock and overflow strobes: timer 1 every 2 clocks, timer 2 every 3
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    tcnt <= tcnt + 1;
    timer1_ovf <= (tcnt % 2 == 0);
    timer2_ovf <= (tcnt % 3 == 0);
  end

  // ==========================================================================
  // Common tasks
  task automatic results();
    $display("Checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) begin
      check("apb ready", 0, 1);
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_bit(input int b, input logic v);
    int k;
    k = 0;
    do begin
      apb(UNB_SERIAL_CONTROL_OFS, 1'b0, 32'h0);
      k++;
    end while (rd[b] !== v && k < 2000);
    if (k >= 2000) begin
      check("flag wait", 0, 1);
      results();
    end
  endtask : wait_bit

  task automatic do_tx(input logic [7:0] d, input logic n9, input int bc);
    int n0;
    n0 = u_unb_remote_node.cap_n;
    u_unb_remote_node.rx_bc = bc;
    ctl_v[UNB_TX_NINTH_BIT] = n9;
    apb(UNB_SERIAL_CONTROL_OFS, 1'b1, ctl_v);
    apb(UNB_SERIAL_BUFFER_OFS, 1'b1, {24'h0, d});
    wait_bit(UNB_SEND_BIT, 1'b1);
    apb(UNB_SERIAL_BUFFER_OFS, 1'b1, 32'hFF);
    wait_bit(UNB_TX_DONE_BIT, 1'b1);
    check("send phase", rd[UNB_SEND_BIT], 0);
    repeat (bc) @(posedge pclk);
    check("tx frame", u_unb_remote_node.cap, {1'b1, n9, d, 1'b0});
    check("tx frames", u_unb_remote_node.cap_n - n0, 1);
    apb(UNB_SERIAL_CONTROL_OFS, 1'b0, 32'h0);
    check("tx done held", rd[UNB_TX_DONE_BIT], 1);
    apb(UNB_SERIAL_CONTROL_OFS, 1'b1, ctl_v | 32'h1);
    apb(UNB_SERIAL_CONTROL_OFS, 1'b0, 32'h0);
    check("tx done clear", rd[UNB_TX_DONE_BIT], 0);
  endtask : do_tx

  task automatic do_rx(input logic [7:0] d, input logic n9, input logic stop, input int bc,
                       input logic load, input logic clr);
    logic [7:0] old;
    logic       pre;
    apb(UNB_SERIAL_BUFFER_OFS, 1'b0, 32'h0);
    old = rd[7:0];
    apb(UNB_SERIAL_CONTROL_OFS, 1'b0, 32'h0);
    pre = rd[UNB_RX_DONE_BIT];
    u_unb_remote_node.send_frame(d, n9, stop, bc);
    repeat (bc) @(posedge pclk);
    apb(UNB_SERIAL_CONTROL_OFS, 1'b0, 32'h0);
    check("rx done", rd[UNB_RX_DONE_BIT], load | pre);
    if (load) check("rx ninth", rd[UNB_RX_NINTH_BIT], n9);
    apb(UNB_SERIAL_BUFFER_OFS, 1'b0, 32'h0);
    check("rx byte", rd[7:0], load ? d : old);
    if (clr) apb(UNB_SERIAL_CONTROL_OFS, 1'b1, ctl_v | 32'h2);
  endtask : do_rx

  // ==========================================================================
  // Scenarios
  task automatic sc_reset();
    apb(UNB_SERIAL_CONTROL_OFS, 1'b0, 32'h0);
    check("control reset", rd, 0);
    apb(UNB_POWER_CONTROL_OFS, 1'b0, 32'h0);
    check("power reset", rd, 0);
    apb(12'h010, 1'b0, 32'h0);
    check("unmapped data", rd, 0);
    check("unmapped error", er, 1);
    check("tx idle", tx_line, 1);
  endtask : sc_reset

  task automatic sc_tx();
    ctl_v = 32'h0;
    do_tx(8'hA5, 1'b1, 64);
    apb(UNB_POWER_CONTROL_OFS, 1'b1, 32'h1 << UNB_DOUBLER_BIT);
    do_tx(8'h3C, 1'b0, 32);
    apb(UNB_POWER_CONTROL_OFS, 1'b1, 32'h0);
    ctl_v = 32'h1 << UNB_MODE_BIT;
    apb(UNB_TIMER2_CONTROL_OFS, 1'b1, 32'h1 << UNB_TX_CSEL_BIT);
    do_tx(8'h96, 1'b1, 48);
    apb(UNB_TIMER2_CONTROL_OFS, 1'b1, 32'h0);
    do_tx(8'h0F, 1'b0, 32);
  endtask : sc_tx

  task automatic sc_rx();
    ctl_v = 32'h1 << UNB_RX_ENABLE_BIT;
    apb(UNB_SERIAL_CONTROL_OFS, 1'b1, ctl_v);
    u_unb_remote_node.glitch(16);
    repeat (128) @(posedge pclk);
    apb(UNB_SERIAL_CONTROL_OFS, 1'b0, 32'h0);
    check("false start flag", rd[UNB_RX_DONE_BIT], 0);
    check("false start busy", rd[UNB_RX_BUSY_BIT], 0);
    do_rx(8'h5A, 1'b1, 1'b1, 64, 1'b1, 1'b1);
    do_rx(8'hC3, 1'b0, 1'b0, 64, 1'b1, 1'b0);
    do_rx(8'h22, 1'b1, 1'b1, 64, 1'b0, 1'b1);
    ctl_v = ctl_v | (32'h1 << UNB_MPF_BIT);
    apb(UNB_SERIAL_CONTROL_OFS, 1'b1, ctl_v);
    do_rx(8'h44, 1'b0, 1'b1, 64, 1'b0, 1'b1);
    u_unb_remote_node.send_frame(8'h55, 1'b0, 1'b1, 64);
    do_rx(8'h77, 1'b1, 1'b1, 64, 1'b1, 1'b1);
    ctl_v = (32'h1 << UNB_RX_ENABLE_BIT) | (32'h1 << UNB_MODE_BIT);
    apb(UNB_TIMER2_CONTROL_OFS, 1'b1, 32'h1 << UNB_RX_CSEL_BIT);
    apb(UNB_SERIAL_CONTROL_OFS, 1'b1, ctl_v);
    do_rx(8'hE1, 1'b1, 1'b1, 48, 1'b1, 1'b1);
    apb(UNB_TIMER2_CONTROL_OFS, 1'b1, 32'h0);
    do_rx(8'h18, 1'b0, 1'b1, 32, 1'b1, 1'b1);
  endtask : sc_rx

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    sc_reset();
    sc_tx();
    sc_rx();
    results();
  end

endmodule : unb_serial_port_test

`default_nettype wire
